// ---- iabh_ctrl.sv ----
// Purpose: interrupt acknowledge sequencing, cpu ready, bus hold and failsafe timeout
// Assumes: all pin inputs asynchronous to pclk; APB master on pclk
// Notes:   outputs all registered; jumpers and vector ids live in the control register
//
// Behaviour
// [R1] busy bus access raises both bus requests
// [R2] bus request unlocks dual-port memory immediately
// [R3] keep bus on lock, hold, or priority; at cycle end the code releases on any common request, even under lock or hold
// [R4] release on unlock or request-then-cycle
// [R5] on-board controller is cascade master
// [R6] all-low status starts acknowledge cycle
// [R7] ack flag and jumper gate arbitration
// [R8] jumper fitted: win bus, bus ack, lock
// [R9] jumper removed: local ack, hit low
// [R10] first pulse freezes priority state
// [R11] first pulse sets first-ack flag
// [R12] first flag plus tap gives ready
// [R13] second local pulse outputs vector, buffer enable
// [R14] data enable plus tap gives ready
// [R15] cpu multiplies vector by four
// [R16] bus mode drives hit high, arbitrates
// [R17] bus won: bus ack, slave freeze, flag
// [R18] first bus ack drives slave id
// [R19] second cycle latches id onto address
// [R20] slave answers vector then transfer ack
// [R21] transfer ack gives ready
// [R22] idle strobe over 4 ms raises timeout
// [R23] enabled timeout forces local ack, ready
// [R24] strobe or reset restarts timeout count
// [R25] take bus: priority low, busy high
//
// The register offsets and the APB slave port were left to the implementer.
`default_nettype none
module iabh_ctrl #(
  parameter int unsigned TIMEOUT_CYCLES = iabh_pkg::TIMEOUT_CYCLES,
  parameter int unsigned TAP_CYCLES     = iabh_pkg::READY_TAP_CYCLES
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire iabh_pkg::iabh_pins_type pins,
  output logic                       bus_request,
  output logic                       common_bus_request,
  output logic                       dpram_locked,
  output logic                       bus_address_enable,
  output logic                       bus_side_ack,
  output logic                       local_ack,
  output logic                       first_ack_flag,
  output logic                       ack_cycle_flag,
  output logic                       offboard_ready,
  output logic                       pic_freeze,
  output logic                       pic_buffer_enable,
  output logic                       pic_data_enable,
  output logic      [7:0]            vector_data,
  output logic      [2:0]            cascade_id_lines,
  output logic      [2:0]            sys_adr_hi,
  output logic                       onboard_address_hit_n,
  output logic                       timeout_irq
);
  // ----------------------------------------------------------------
  // parameter checks
  // ----------------------------------------------------------------
  if (TIMEOUT_CYCLES < 2 || TIMEOUT_CYCLES > 65535) begin : g_chk_tmo
    $error("TIMEOUT_CYCLES out of range");
  end
  if (TAP_CYCLES < 1 || TAP_CYCLES > 15) begin : g_chk_tap
    $error("TAP_CYCLES out of range");
  end

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  iabh_pkg::iabh_pins_type s1_r, s2_r;
  logic [2:0]              st_prev_r;
  logic                    ale_prev_r;

  // two flops before any logic reads a pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // idle levels, so no false request or strobe right after reset
      s1_r       <= '{status: 3'h7, access_req: 1'b0, ale: 1'b0, default: 1'b1};
      s2_r       <= '{status: 3'h7, access_req: 1'b0, ale: 1'b0, default: 1'b1};
      st_prev_r  <= 3'h7;
      ale_prev_r <= 1'b0;
    end else begin
      s1_r       <= pins;
      s2_r       <= s1_r;
      st_prev_r  <= s2_r.status;
      ale_prev_r <= s2_r.ale;
    end
  end

  logic ack_start, ale_pulse, lock_on, hold_on, prio_on, busy_on, cbrq_on, xack_on;
  assign ack_start = (s2_r.status == iabh_pkg::ACK_STATUS) &&
                     (st_prev_r != iabh_pkg::ACK_STATUS);            // see [R6]
  assign ale_pulse = s2_r.ale && !ale_prev_r;
  assign lock_on   = !s2_r.lock_n;
  assign hold_on   = !s2_r.hold_a_n;
  assign prio_on   = !s2_r.prio_n;
  assign busy_on   = !s2_r.busy_n;
  assign cbrq_on   = !s2_r.cbrq_n;
  assign xack_on   = !s2_r.xack_n;

  // ----------------------------------------------------------------
  // APB registers
  // ----------------------------------------------------------------
  iabh_pkg::iabh_ctrl_type ctrl_r;
  logic                    wr_en, rd_hit;
  logic [31:0]             rd_val;
  iabh_pkg::iabh_state_type state_r, state_nxt;
  logic                    owned_r, in_ack_r, bv_cycle_r;

  assign wr_en = psel && penable && pready && pwrite;

  // control register steers jumpers, mode and vector ids
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= iabh_pkg::iabh_ctrl_type'({iabh_pkg::CTRL_RESET[15:iabh_pkg::CTRL_VEC_LSB],
                iabh_pkg::CTRL_RESET[iabh_pkg::CTRL_SLV_LSB +: 3], iabh_pkg::CTRL_RESET[iabh_pkg::CTRL_BV_BIT],
                iabh_pkg::CTRL_RESET[iabh_pkg::CTRL_TMO_BIT], iabh_pkg::CTRL_RESET[iabh_pkg::CTRL_ARB_BIT]});
    end else if (wr_en && paddr == iabh_pkg::CTRL_OFFS) begin
      ctrl_r <= iabh_pkg::iabh_ctrl_type'({pwdata[15:iabh_pkg::CTRL_VEC_LSB],
                pwdata[iabh_pkg::CTRL_SLV_LSB +: 3], pwdata[iabh_pkg::CTRL_BV_BIT],
                pwdata[iabh_pkg::CTRL_TMO_BIT], pwdata[iabh_pkg::CTRL_ARB_BIT]});
    end
  end

  // read mux, zero for reserved bits
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    case (paddr)
      iabh_pkg::CTRL_OFFS: begin
        rd_val[15:iabh_pkg::CTRL_VEC_LSB]       = ctrl_r.vector_id;
        rd_val[iabh_pkg::CTRL_SLV_LSB +: 3]     = ctrl_r.slave_id;
        rd_val[iabh_pkg::CTRL_BV_BIT]           = ctrl_r.bv_mode;
        rd_val[iabh_pkg::CTRL_TMO_BIT]          = ctrl_r.tmo_en;
        rd_val[iabh_pkg::CTRL_ARB_BIT]          = ctrl_r.arb_jumper;
      end
      iabh_pkg::STAT_OFFS: begin
        rd_val = {16'h0000, 1'b0, state_r, owned_r, in_ack_r, bv_cycle_r,
                  timeout_irq, first_ack_flag, ack_cycle_flag, bus_request, offboard_ready};
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  // zero-wait slave: ready is raised in the setup cycle's following edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !rd_hit;
      if (psel && !penable) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_val;
      end
    end
  end

  // ----------------------------------------------------------------
  // failsafe timer
  // ----------------------------------------------------------------
  logic [15:0] tmo_cnt_r;
  logic        tmo_fire;

  // restarts on every strobe; saturates once expired
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmo_cnt_r   <= 16'h0000;                                        // see [R24]
      timeout_irq <= 1'b0;
    end else if (ale_pulse) begin
      tmo_cnt_r   <= 16'h0000;                                        // see [R24]
      timeout_irq <= 1'b0;
    end else if (tmo_cnt_r != 16'(TIMEOUT_CYCLES)) begin
      tmo_cnt_r   <= tmo_cnt_r + 16'h0001;
    end else begin
      timeout_irq <= 1'b1;                                            // see [R22]
    end
  end
  // only a jumpered timeout may end a stalled wait
  assign tmo_fire = timeout_irq && ctrl_r.tmo_en;                     // see [R23]

  // ----------------------------------------------------------------
  // ready timing tap
  // ----------------------------------------------------------------
  logic [3:0] tap_r;
  logic       tap_hit;
  assign tap_hit = (tap_r == 4'(TAP_CYCLES - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tap_r <= 4'h0;
    end else if ((state_r == iabh_pkg::ST_ACK1 || state_r == iabh_pkg::ST_ACK2) && !tap_hit) begin
      tap_r <= tap_r + 4'h1;
    end else if (state_r != iabh_pkg::ST_ACK1 && state_r != iabh_pkg::ST_ACK2) begin
      tap_r <= 4'h0;
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  logic need_bus, win, ack2_done, retain;
  // the on-board controller always acts as cascade master, never slave
  assign need_bus  = ctrl_r.bv_mode || ctrl_r.arb_jumper;             // see [R5] see [R7]
  assign win       = prio_on && !busy_on;                             // see [R25]
  assign ack2_done = bv_cycle_r ? (xack_on || tmo_fire) : tap_hit;    // see [R21] see [R14]
  assign retain    = (lock_on || hold_on || (prio_on && !cbrq_on)) && !cbrq_on; // see [R3] see [R4]

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      iabh_pkg::ST_IDLE: begin
        if (ack_start) begin
          state_nxt = (need_bus && !owned_r) ? iabh_pkg::ST_ARB : iabh_pkg::ST_ACK1;
        end else if (s2_r.access_req) begin
          state_nxt = owned_r ? iabh_pkg::ST_XFER : iabh_pkg::ST_ARB;
        end
      end
      iabh_pkg::ST_ARB: begin
        if (win) begin
          state_nxt = in_ack_r ? iabh_pkg::ST_ACK1 : iabh_pkg::ST_XFER;
        end
      end
      iabh_pkg::ST_XFER: begin
        if (xack_on || tmo_fire) begin
          state_nxt = iabh_pkg::ST_FIN;
        end
      end
      iabh_pkg::ST_ACK1: begin
        if (tap_hit) begin
          state_nxt = iabh_pkg::ST_GAP;                               // see [R12]
        end
      end
      iabh_pkg::ST_GAP: begin
        if (ack_start) begin
          state_nxt = iabh_pkg::ST_ACK2;
        end else if (tmo_fire) begin
          state_nxt = iabh_pkg::ST_FIN;
        end
      end
      iabh_pkg::ST_ACK2: begin
        if (ack2_done) begin
          state_nxt = iabh_pkg::ST_FIN;
        end
      end
      iabh_pkg::ST_FIN: begin
        if (!s2_r.access_req || in_ack_r) begin
          state_nxt = iabh_pkg::ST_IDLE;
        end
      end
      default: begin
        state_nxt = iabh_pkg::ST_IDLE;
      end
    endcase
  end

  // state, bus ownership and cycle kind
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r    <= iabh_pkg::ST_IDLE;
      owned_r    <= 1'b0;
      in_ack_r   <= 1'b0;
      bv_cycle_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (state_r == iabh_pkg::ST_IDLE && ack_start) begin
        in_ack_r   <= 1'b1;
        bv_cycle_r <= ctrl_r.bv_mode;
      end else if (state_r == iabh_pkg::ST_IDLE && s2_r.access_req) begin
        in_ack_r   <= 1'b0;
        bv_cycle_r <= 1'b0;
      end
      if (state_r == iabh_pkg::ST_ARB && win) begin
        owned_r <= 1'b1;                                              // see [R25]
      end else if (state_r == iabh_pkg::ST_FIN && !retain) begin
        owned_r <= 1'b0;                                              // see [R4]
      end else if (state_r == iabh_pkg::ST_IDLE && owned_r && !lock_on && !hold_on &&
                   !(prio_on && !cbrq_on)) begin
        owned_r <= 1'b0;                                              // see [R4]
      end
    end
  end

  // ----------------------------------------------------------------
  // registered outputs, taken from the next and the current state; offboard_ready decodes the current state alone
  // ----------------------------------------------------------------
  logic nx_arb, nx_a1, nx_a2, nx_ack, nx_local, bus_ack_path, vec_hold;
  assign nx_arb   = (state_nxt == iabh_pkg::ST_ARB);
  assign nx_a1    = (state_nxt == iabh_pkg::ST_ACK1);
  assign nx_a2    = (state_nxt == iabh_pkg::ST_ACK2);
  assign nx_ack   = nx_a1 || nx_a2 || (state_nxt == iabh_pkg::ST_GAP);
  // a cycle latched before the decision still decides kind for the whole sequence
  assign bus_ack_path = (state_r == iabh_pkg::ST_IDLE) ? need_bus : (bv_cycle_r || ctrl_r.arb_jumper);
  assign nx_local = !bus_ack_path;
  // vector stays up through the ready pulse so the cpu can still take it
  assign vec_hold = (nx_a2 || state_r == iabh_pkg::ST_ACK2) && !bv_cycle_r;

  // arbitration and memory lock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_request        <= 1'b0;
      common_bus_request <= 1'b0;
      dpram_locked       <= 1'b0;
      bus_address_enable <= 1'b0;
    end else begin
      bus_request        <= nx_arb;                                   // see [R1]
      common_bus_request <= nx_arb && busy_on;                        // see [R1]
      // lock falls in the same edge that the request rises
      dpram_locked       <= lock_on && !nx_arb;                       // see [R2]
      bus_address_enable <= (owned_r || (state_r == iabh_pkg::ST_ARB && win)) &&
                            (state_nxt == iabh_pkg::ST_XFER || (nx_ack && bus_ack_path)); // see [R17]
    end
  end

  // acknowledge sequencing outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_cycle_flag        <= 1'b0;
      first_ack_flag        <= 1'b0;
      pic_freeze            <= 1'b0;
      bus_side_ack          <= 1'b0;
      local_ack             <= 1'b0;
      offboard_ready        <= 1'b0;
      onboard_address_hit_n <= 1'b1;
    end else begin
      ack_cycle_flag <= nx_ack || (nx_arb && (in_ack_r || (state_r == iabh_pkg::ST_IDLE && ack_start)));
      first_ack_flag <= nx_a1 || (state_nxt == iabh_pkg::ST_GAP);     // see [R11] see [R17]
      pic_freeze     <= nx_ack;                                       // see [R10]
      bus_side_ack   <= (nx_a1 || nx_a2) && bus_ack_path;             // see [R8] see [R17]
      local_ack      <= ((nx_a1 || nx_a2) && !bv_cycle_r && !(state_r == iabh_pkg::ST_IDLE && ctrl_r.bv_mode))
                        || tmo_fire;                                  // see [R9] see [R23]
      offboard_ready <= (state_r == iabh_pkg::ST_ACK1 && tap_hit) ||  // see [R12]
                        (state_r == iabh_pkg::ST_ACK2 && ack2_done) ||// see [R14] see [R21]
                        (state_r == iabh_pkg::ST_XFER && (xack_on || tmo_fire)) ||
                        (state_r == iabh_pkg::ST_GAP && tmo_fire);    // see [R23]
      onboard_address_hit_n <= !((nx_ack || state_r == iabh_pkg::ST_ACK2) && nx_local); // see [R9] see [R16]
    end
  end

  // vector and cascade id paths
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pic_buffer_enable <= 1'b0;
      pic_data_enable   <= 1'b0;
      vector_data       <= 8'h00;
      cascade_id_lines  <= 3'h0;
      sys_adr_hi        <= 3'h0;
    end else begin
      pic_buffer_enable <= vec_hold;                                  // see [R13]
      pic_data_enable   <= vec_hold;                                  // see [R14]
      vector_data       <= vec_hold ? ctrl_r.vector_id : 8'h00;       // see [R13]
      if (nx_a1 && bus_ack_path && ctrl_r.bv_mode) begin
        cascade_id_lines <= ctrl_r.slave_id;                          // see [R18]
      end else if (!nx_ack) begin
        cascade_id_lines <= 3'h0;
      end
      if (state_r == iabh_pkg::ST_GAP && nx_a2 && bv_cycle_r) begin
        sys_adr_hi <= cascade_id_lines;                               // see [R19]
      end else if (!nx_a2 && state_r != iabh_pkg::ST_ACK2) begin
        sys_adr_hi <= 3'h0;
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_first_done;
    first_ack_flag ##[1:20] offboard_ready;
  endsequence

  a_breq_unlocks: assert property (bus_request |-> !dpram_locked)               // see [R2]
    else $error("memory lock held while bus requested");
  a_cbrq_with_breq: assert property (common_bus_request |-> bus_request)        // see [R1]
    else $error("common request without bus request");
  a_take_needs_win: assert property ($rose(owned_r) |-> $past(prio_on) && !$past(busy_on)) // see [R25]
    else $error("bus taken without priority or while busy");
  a_first_ready: assert property ($rose(first_ack_flag) |-> s_first_done)       // see [R12]
    else $error("first acknowledge never readied");
  a_freeze_first: assert property ($rose(first_ack_flag) |-> pic_freeze)        // see [R10]
    else $error("priority not frozen on first pulse");
  a_vec_buffer: assert property (pic_buffer_enable |-> pic_data_enable && vector_data == ctrl_r.vector_id) // see [R13]
    else $error("vector not driven with buffer enable");
  a_local_hit_low: assert property (pic_buffer_enable && !ctrl_r.arb_jumper |-> !onboard_address_hit_n) // see [R9]
    else $error("local acknowledge with hit high");
  a_tmo_expire: assert property (tmo_cnt_r == 16'(TIMEOUT_CYCLES) && !ale_pulse |=> timeout_irq) // see [R22]
    else $error("timeout not raised after idle interval");
  a_tmo_restart: assert property (ale_pulse |=> tmo_cnt_r == 16'h0000 && !timeout_irq) // see [R24]
    else $error("timeout not restarted by strobe");
  a_xack_ready: assert property (state_r == iabh_pkg::ST_ACK2 && bv_cycle_r && xack_on
                                 |=> offboard_ready)                             // see [R21]
    else $error("transfer ack did not ready the cpu");
endmodule : iabh_ctrl
`default_nettype wire

// ---- iabh_pkg.sv ----
// Purpose: shared constants and types for the acknowledge, ready and bus hold glue
// Assumes: 10 MHz pclk
// Notes:   register offsets are byte addresses on APB
`default_nettype none
package iabh_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned TIMEOUT_MS      = 4;
  localparam int unsigned TIMEOUT_CYCLES  = (CLK_HZ / 1000) * TIMEOUT_MS;
  localparam int unsigned READY_TAP_CYCLES = 2;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0]  CTRL_OFFS       = 8'h00;
  localparam logic [7:0]  STAT_OFFS       = 8'h04;
  localparam logic [31:0] CTRL_RESET      = 32'h0000_0003;
  localparam int unsigned CTRL_ARB_BIT    = 0;
  localparam int unsigned CTRL_TMO_BIT    = 1;
  localparam int unsigned CTRL_BV_BIT     = 2;
  localparam int unsigned CTRL_SLV_LSB    = 4;
  localparam int unsigned CTRL_VEC_LSB    = 8;
  // acknowledge status pattern on the three cpu status lines
  localparam logic [2:0]  ACK_STATUS      = 3'h0;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] vector_id;
    logic [2:0] slave_id;
    logic       bv_mode;
    logic       tmo_en;
    logic       arb_jumper;
  } iabh_ctrl_type;

  typedef struct packed {
    logic       access_req;
    logic       xack_n;
    logic       cbrq_n;
    logic       busy_n;
    logic       prio_n;
    logic       hold_a_n;
    logic       lock_n;
    logic       ale;
    logic [2:0] status;
  } iabh_pins_type;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_ARB  = 7'h02,
    ST_XFER = 7'h04,
    ST_ACK1 = 7'h08,
    ST_GAP  = 7'h10,
    ST_ACK2 = 7'h20,
    ST_FIN  = 7'h40
  } iabh_state_type;
endpackage : iabh_pkg
`default_nettype wire

// ---- iabh_bus_partner.sv ----
// Purpose: far-side model of the shared bus, arbitration lines and slave transfer ack
// Assumes: single pclk domain, levels active low as on the bus
// Notes:   ack delay is set once per run by the bench from its fixed seed, so every run sees the same slave delay
`default_nettype none
module iabh_bus_partner (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       other_busy,
  input  wire logic       bus_address_enable,
  input  wire logic       bus_side_ack,
  input  wire logic [2:0] sys_adr_hi,
  input  wire logic [2:0] my_id,
  input  wire logic [3:0] delay,
  output logic            xack_n,
  output logic            busy_n,
  output logic            prio_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt_r;
  // priority always granted; busy only while another master owns the bus
  assign prio_n = 1'b0;
  assign busy_n = !other_busy;
  // slave acks only its own id or a plain transfer; ack drops once board lets go
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r  <= 4'h0;
      xack_n <= 1'b1;
    end else if (bus_address_enable && (!bus_side_ack || sys_adr_hi == my_id)) begin
      cnt_r  <= (cnt_r == 4'hF) ? cnt_r : cnt_r + 4'h1;
      xack_n <= !(cnt_r >= delay);
    end else begin
      cnt_r  <= 4'h0;
      xack_n <= 1'b1;
    end
  end
endmodule : iabh_bus_partner
`default_nettype wire

// ---- testbench.sv ----
// Purpose: self-checking bench for acknowledge, ready, bus hold and failsafe timeout
// Assumes: 10 MHz pclk, short timeout parameter to keep the run brief
// Notes:   random vector, slave id and slave delay from a fixed xorshift seed
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned TMO = 200;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, acc, lock_n, ale, busy_o, cbrq_i, acf;
  logic [7:0] paddr, vec;
  logic [31:0] pwdata, prdata, rd, rng;
  logic [2:0] st, sid, cas, adr;
  logic [3:0] dly;
  logic xack_n, busy_n, prio_n, breq, cbrq, dpl, baen, bsack, lack, first, rdy, frz, pbe, pde, hit_n, tmo, err;
  logic [7:0] vdat;
  iabh_pkg::iabh_pins_type pins;
  int error_cnt, compares;
  assign pins = {acc, xack_n, cbrq_i, busy_n, prio_n, 1'b1, lock_n, ale, st};
  iabh_ctrl #(.TIMEOUT_CYCLES(TMO), .TAP_CYCLES(2)) u_iabh_ctrl (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pins(pins), .bus_request(breq), .common_bus_request(cbrq),
    .dpram_locked(dpl), .bus_address_enable(baen), .bus_side_ack(bsack), .local_ack(lack),
    .first_ack_flag(first), .ack_cycle_flag(acf), .offboard_ready(rdy), .pic_freeze(frz),
    .pic_buffer_enable(pbe), .pic_data_enable(pde), .vector_data(vdat), .cascade_id_lines(cas),
    .sys_adr_hi(adr), .onboard_address_hit_n(hit_n), .timeout_irq(tmo));
  iabh_bus_partner u_iabh_bus_partner (.pclk(pclk), .presetn(presetn), .other_busy(busy_o),
    .bus_address_enable(baen), .bus_side_ack(bsack), .sys_adr_hi(adr), .my_id(sid), .delay(dly),
    .xack_n(xack_n), .busy_n(busy_n), .prio_n(prio_n));
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    compares++;
    if (s !== e) begin
      error_cnt++;
      $display("wrong value %s exp %h got %h", n, e, s);
    end
  endtask : chk
  // one apb transfer; held until pready is seen at a falling edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    // look mid-cycle; the transfer completes at the next rising edge
    do @(negedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    @(posedge pclk);
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  // cpu status change with its strobe; ends mid-cycle once the edge is seen
  task automatic stat(input logic [2:0] v);
    @(posedge pclk);
    st <= v; ale <= 1'b1;
    @(posedge pclk);
    ale <= 1'b0;
    repeat (2) @(posedge pclk);
    @(negedge pclk);
  endtask : stat
  // bounded wait for the one-cycle ready pulse, sampled mid-cycle
  task automatic wait_rdy;
    int k;
    k = 0;
    while (rdy !== 1'b1 && k < 300) begin @(negedge pclk); k++; end
  endtask : wait_rdy
  task automatic conclude;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    conclude;
  end
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, acc, ale, busy_o} = '0; paddr = '0; pwdata = '0;
    lock_n = 1'b1; cbrq_i = 1'b1; st = 3'h7; presetn = 1'b0; error_cnt = 0; compares = 0; rng = 32'h3;
    rng = xs(rng); vec = rng[7:0]; sid = 3'(rng[10:8] % 7 + 1); dly = rng[15:12];
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, iabh_pkg::CTRL_OFFS, '0);
    chk("ctrl reset", iabh_pkg::CTRL_RESET, rd);
    apb(1'b0, 8'h0C, '0);
    chk("unmapped err", 1'b1, err);
    // local vector, jumper removed: acks stay on board
    apb(1'b1, iabh_pkg::CTRL_OFFS, {16'h0, vec, 1'b0, sid, 4'h2});
    stat(3'h0);
    chk("hit low", 1'b0, hit_n);
    chk("local ack", 1'b1, lack);
    chk("no breq", 1'b0, breq);
    chk("ack cycle", 1'b1, acf);
    chk("freeze", 1'b1, frz);
    chk("first flag", 1'b1, first);
    wait_rdy; chk("ready 1", 1'b1, rdy);
    stat(3'h7);
    stat(3'h0);
    wait_rdy; chk("ready 2", 1'b1, rdy);
    chk("vector", vec, vdat);
    chk("isr addr", 32'(vec) << 2, 32'(vdat) * 4);
    chk("buf en", 1'b1, pbe);
    chk("data en", 1'b1, pde);
    stat(3'h7);
    // busy bus access under lock: both requests, memory unlocked
    @(posedge pclk);
    lock_n <= 1'b0; busy_o <= 1'b1;
    stat(3'h7);
    chk("lock held", 1'b1, dpl);
    @(posedge pclk);
    acc <= 1'b1;
    repeat (5) @(posedge pclk);
    @(negedge pclk);
    chk("breq", 1'b1, breq);
    chk("cbrq", 1'b1, cbrq);
    chk("unlock", 1'b0, dpl);
    @(posedge pclk);
    busy_o <= 1'b0;
    wait_rdy; chk("xfer ready", 1'b1, rdy);
    @(posedge pclk);
    acc <= 1'b0;
    apb(1'b0, iabh_pkg::STAT_OFFS, '0);
    chk("kept", 1'b1, rd[7]);
    // lock gone and a common request seen: ownership given up
    lock_n <= 1'b1; cbrq_i <= 1'b0;
    repeat (6) @(posedge pclk);
    apb(1'b0, iabh_pkg::STAT_OFFS, '0);
    chk("released", 1'b0, rd[7]);
    cbrq_i <= 1'b1;
    // bus vectored: slave id on cascade lines then system address
    apb(1'b1, iabh_pkg::CTRL_OFFS, {16'h0, vec, 1'b0, sid, 4'h7});
    stat(3'h0);
    chk("hit high", 1'b1, hit_n);
    @(negedge pclk);
    chk("bus ack", 1'b1, bsack);
    chk("cas id", sid, cas);
    wait_rdy; chk("bv ready 1", 1'b1, rdy);
    stat(3'h7);
    stat(3'h0);
    wait_rdy; chk("adr hi", sid, adr);
    chk("xack ready", 1'b1, rdy);
    stat(3'h7);
    // failsafe: strobe restarts the count, then a full idle span fires it
    repeat (TMO - 20) @(posedge pclk);
    stat(3'h7);
    repeat (TMO - 20) @(posedge pclk);
    chk("no tmo", 1'b0, tmo);
    repeat (30) @(posedge pclk);
    chk("tmo", 1'b1, tmo);
    chk("tmo local ack", 1'b1, lack);
    stat(3'h7);
    chk("tmo clr", 1'b0, tmo);
    conclude;
  end
endmodule : testbench
`default_nettype wire
